// *** rtl/stfs_frame_scheduler.sv ***
// slow-speed downlink frame scheduler and real-time payload packer
//
// Functional notes
// R01: while keyed, each frame takes next type of the 24-entry rotation
// R02: after the last rotation entry, start again at the first
// R03: every new keying starts the rotation at its first entry
// R04: keying drops only at a frame boundary
// R05: beacons send set 1,2 then set 1,3, alternating per beacon
// R06: type 2 or 3 beacon frame goes out with the voice id
// R07: debug type 0 only when not in flight configuration
// R08: real-time payload is 429 bits from offset zero
// R09: battery volts, temperatures at 0..60, board temperature at 84
// R10: signed total battery current at offset 72
// R11: panel volts at 96..156, panel temperatures at 168..228
// R12: signed spin rate at 252, after supply temperature at 240
// R13: five radio and processor fields at 264..312
// R14: angular rates 324..348, experiment temp 360, supply current 372
// R15: 32-bit processor diagnostic word at offset 384
// R16: four experiment failure flags at offset 416, one per experiment
// R17: each byte goes out most significant bit first
// R18: multi-byte values go out least significant byte first
// R19: types 1..3 padded with zeros to 58 bytes
// R20: frame type code tells the header which payload type is sent
`timescale 1ns/1ps
`include "stfs_regs.svh"

module stfs_frame_scheduler (
  input wire logic ref_clk_i, // 25 MHz system clock
  input wire logic nrst_i, // async reset, active low
  input wire logic keying_req_i, // level: transmit wanted
  input wire logic beacon_req_i, // pulse: idle timer expired
  input wire logic flight_cfg_i, // level: flight configuration
  input wire logic debug_sel_i, // level: ground debug frames wanted
  input wire logic frame_done_i, // pulse: link frame fully sent
  input wire logic [`STFS_W3-1:0] pack_volt_i, // pairs a,b,c
  input wire logic [`STFS_W3-1:0] pack_temp_i, // pairs a,b,c
  input wire logic [`STFS_FLD_W-1:0] pack_curr_i, // signed
  input wire logic [`STFS_FLD_W-1:0] pack_brd_temp_i, // board temp
  input wire logic [`STFS_W6-1:0] panel_volt_i, // +x,-x,+y,-y,+z,-z
  input wire logic [`STFS_W6-1:0] panel_temp_i, // +x,-x,+y,-y,+z,-z
  input wire logic [`STFS_FLD_W-1:0] supply_temp_i, // supply temp
  input wire logic [`STFS_FLD_W-1:0] spin_i, // sign,int 3,frac 8
  input wire logic [`STFS_W5-1:0] radio_i, // amp i,tx t,rx t,rssi,cpu t
  input wire logic [`STFS_W3-1:0] ang_vel_i, // x,y,z rates
  input wire logic [`STFS_FLD_W-1:0] exp_four_temp_i, // experiment four
  input wire logic [`STFS_FLD_W-1:0] supply_curr_i, // supply current
  input wire logic [`STFS_DIAG_W-1:0] diag_i, // processor diagnostic
  input wire logic [`STFS_FAIL_W-1:0] exp_fail_i, // 1 = failed
  input wire logic [`STFS_TAIL_W-1:0] tail_i, // status bits 420..428
  input wire logic byte_ready_i, // transmitter takes byte
  output logic transmit_keying_o, // level: transmitter keyed
  output logic frame_start_o, // pulse: new frame begins
  output logic [3:0] frame_type_o, // payload type of frame
  output logic voice_id_o, // level: play voice id now
  output logic [7:0] byte_o, // payload byte
  output logic byte_valid_o // byte_o holds a byte
);
  import stfs_pkg::*;

  stfs_state_t state_r;
  stfs_mode_t mode_r;
  logic [4:0] rot_idx_r;
  logic bcn_frame_r;
  logic bcn_set_r;
  logic bcn_pend_r;
  logic [5:0] byte_idx_r;
  logic [`STFS_PAD_BITS-1:0] payload_r;
  logic [`STFS_PAD_BITS-1:0] payload_c;
  logic [3:0] sel_type;
  logic start_rot;
  logic start_bcn;
  logic frame_end;
  logic next_rot;
  logic next_bcn;
  logic end_tx;
  logic go_start;
  logic buf_in_ready;
  logic buf_in_valid;
  logic [7:0] buf_in_data;
  logic buf_in_fire;

  // ****************************************
  // rotation table
  // ****************************************
  function automatic logic [3:0] rot_type(input logic [4:0] idx);
    if (idx == `STFS_ROT_MAXV_IDX) begin
      rot_type = `STFS_PTYPE_MAXV;
    end else if (idx == `STFS_ROT_MINV_IDX) begin
      rot_type = `STFS_PTYPE_MINV;
    end else if ((idx % `STFS_ROT_STRIDE) == 5'h00) begin
      rot_type = `STFS_PTYPE_RT;
    end else begin
      rot_type = `STFS_PTYPE_RAD;
    end
  endfunction : rot_type

  // ****************************************
  // sequencing decisions
  // ****************************************
  assign start_rot = (state_r == STFS_S_IDLE) && keying_req_i;
  assign start_bcn = (state_r == STFS_S_IDLE) && !keying_req_i &&
                     bcn_pend_r;
  assign frame_end = (state_r == STFS_S_WAIT) && frame_done_i;
  assign next_rot = frame_end && (mode_r == STFS_M_ROT) && keying_req_i;
  assign next_bcn = frame_end && (mode_r == STFS_M_BCN) && !bcn_frame_r;
  assign end_tx = frame_end && !next_rot && !next_bcn;
  assign go_start = start_rot || start_bcn || next_rot || next_bcn;

  always_comb begin
    if (mode_r == STFS_M_BCN) begin
      if (!bcn_frame_r) begin
        sel_type = `STFS_PTYPE_RT; // R05
      end else begin
        sel_type = bcn_set_r ? `STFS_PTYPE_MINV : `STFS_PTYPE_MAXV; // R05
      end
    end else if (debug_sel_i && !flight_cfg_i) begin
      sel_type = `STFS_PTYPE_DEBUG; // R07
    end else begin
      sel_type = rot_type(rot_idx_r); // R01
    end
  end

  // ****************************************
  // frame state machine
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= STFS_S_IDLE;
    end else begin
      case (state_r)
        STFS_S_IDLE: begin
          if (start_rot || start_bcn) begin
            state_r <= STFS_S_START;
          end
        end
        STFS_S_START: begin
          if (sel_type == `STFS_PTYPE_DEBUG ||
              sel_type == `STFS_PTYPE_RAD) begin
            state_r <= STFS_S_WAIT;
          end else begin
            state_r <= STFS_S_STREAM;
          end
        end
        STFS_S_STREAM: begin
          if (buf_in_fire && byte_idx_r == `STFS_LAST_BYTE) begin
            state_r <= STFS_S_WAIT;
          end
        end
        default: begin
          if (go_start) begin
            state_r <= STFS_S_START;
          end else if (end_tx) begin
            state_r <= STFS_S_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // rotation pointer and mode
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rot_idx_r <= 5'h00;
      mode_r <= STFS_M_ROT;
    end else if (start_rot) begin
      rot_idx_r <= 5'h00; // R03
      mode_r <= STFS_M_ROT;
    end else if (start_bcn) begin
      mode_r <= STFS_M_BCN;
    end else if (next_rot) begin
      if (rot_idx_r == `STFS_ROT_LAST) begin
        rot_idx_r <= 5'h00; // R02
      end else begin
        rot_idx_r <= rot_idx_r + 5'h01; // R01
      end
    end
  end

  // ****************************************
  // beacon sets
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bcn_pend_r <= 1'b0;
      bcn_frame_r <= 1'b0;
      bcn_set_r <= 1'b0;
    end else begin
      // a new expiry in the take-up cycle wins over the clear
      if (beacon_req_i) begin
        bcn_pend_r <= 1'b1;
      end else if (start_bcn) begin
        bcn_pend_r <= 1'b0;
      end
      if (start_bcn) begin
        bcn_frame_r <= 1'b0;
      end else if (next_bcn) begin
        bcn_frame_r <= 1'b1;
      end
      if (end_tx && mode_r == STFS_M_BCN) begin
        bcn_set_r <= !bcn_set_r; // R05
      end
    end
  end

  // ****************************************
  // keying, frame start, voice id
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      transmit_keying_o <= 1'b0;
      frame_start_o <= 1'b0;
      frame_type_o <= `STFS_RST_TYPE;
      voice_id_o <= 1'b0;
    end else begin
      frame_start_o <= (state_r == STFS_S_START);
      if (start_rot || start_bcn) begin
        transmit_keying_o <= 1'b1;
      end else if (end_tx) begin
        transmit_keying_o <= 1'b0; // R04
      end
      if (state_r == STFS_S_START) begin
        frame_type_o <= sel_type; // R20
        voice_id_o <= (mode_r == STFS_M_BCN) && bcn_frame_r; // R06
      end else if (frame_end) begin
        voice_id_o <= 1'b0; // R06
      end
    end
  end

  // ****************************************
  // real-time payload map, low offset = low bit
  // ****************************************
  always_comb begin
    payload_c = '0; // R19
    payload_c[`STFS_OFF_PACK_V +: `STFS_W3] = pack_volt_i; // R09
    payload_c[`STFS_OFF_PACK_T +: `STFS_W3] = pack_temp_i; // R09
    payload_c[`STFS_OFF_PACK_I +: `STFS_FLD_W] = pack_curr_i; // R10
    payload_c[`STFS_OFF_BRD_T +: `STFS_FLD_W] = pack_brd_temp_i; // R09
    payload_c[`STFS_OFF_PANEL_V +: `STFS_W6] = panel_volt_i; // R11
    payload_c[`STFS_OFF_PANEL_T +: `STFS_W6] = panel_temp_i; // R11
    payload_c[`STFS_OFF_SUPPLY_T +: `STFS_FLD_W] = supply_temp_i; // R12
    payload_c[`STFS_OFF_SPIN +: `STFS_FLD_W] = spin_i; // R12
    payload_c[`STFS_OFF_RADIO +: `STFS_W5] = radio_i; // R13
    payload_c[`STFS_OFF_ANG +: `STFS_W3] = ang_vel_i; // R14
    payload_c[`STFS_OFF_EXP_FOUR_T +: `STFS_FLD_W] = exp_four_temp_i; // R14
    payload_c[`STFS_OFF_SUPPLY_I +: `STFS_FLD_W] = supply_curr_i; // R14
    payload_c[`STFS_OFF_DIAG +: `STFS_DIAG_W] = diag_i; // R15
    payload_c[`STFS_OFF_EXP_FAIL +: `STFS_FAIL_W] = exp_fail_i; // R16
    payload_c[`STFS_OFF_TAIL +: `STFS_TAIL_W] = tail_i; // R08
  end

  // snapshot at frame start so a frame never mixes two samples
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      payload_r <= '0;
    end else if (state_r == STFS_S_START) begin
      payload_r <= payload_c; // R08
    end
  end

  // ****************************************
  // byte streaming, byte 0 holds offsets 0..7
  // ****************************************
  assign buf_in_valid = (state_r == STFS_S_STREAM);
  assign buf_in_data = payload_r[{byte_idx_r, 3'h0} +: 8]; // R18
  assign buf_in_fire = buf_in_valid && buf_in_ready;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      byte_idx_r <= 6'h00;
    end else if (state_r == STFS_S_START) begin
      byte_idx_r <= 6'h00;
    end else if (buf_in_fire) begin
      byte_idx_r <= byte_idx_r + 6'h01; // R19
    end
  end

  // byte_o[7] is the bit the modulator sends first
  stfs_pair_buffer #(
    .WIDTH(8)
  ) u_pair_buffer (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(buf_in_valid),
    .in_data_i(buf_in_data),
    .in_ready_o(buf_in_ready),
    .out_valid_o(byte_valid_o), // R17
    .out_data_o(byte_o),
    .out_ready_i(byte_ready_i)
  );

  // ****************************************
  // checks
  // ****************************************
  sequence s_rot_keyed;
    $rose(transmit_keying_o) && mode_r == STFS_M_ROT;
  endsequence

  sequence s_first_frame;
    ##1 frame_start_o && frame_type_o == `STFS_PTYPE_RT;
  endsequence

  sequence s_bcn_second;
    frame_start_o && mode_r == STFS_M_BCN && bcn_frame_r;
  endsequence

  a_rot_restart: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (s_rot_keyed and !debug_sel_i) |->
      rot_idx_r == 5'h00 ##0 s_first_frame)
    else $error("rotation did not restart at entry one"); // R03

  a_rot_maxv_slot: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i)
    frame_start_o && mode_r == STFS_M_ROT &&
    frame_type_o == `STFS_PTYPE_MAXV |-> rot_idx_r == 5'h0A)
    else $error("type 2 sent outside eleventh slot"); // R01

  a_rot_wrap: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    next_rot && rot_idx_r == `STFS_ROT_LAST |=> rot_idx_r == 5'h00)
    else $error("rotation did not wrap"); // R02

  a_key_boundary: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i)
    $fell(transmit_keying_o) |-> $past(frame_end))
    else $error("keying dropped inside a frame"); // R04

  a_bcn_alternate: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i)
    s_bcn_second |-> frame_type_o ==
      (bcn_set_r ? `STFS_PTYPE_MINV : `STFS_PTYPE_MAXV))
    else $error("beacon set order wrong"); // R05

  a_voice_sync: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_bcn_second |-> voice_id_o throughout
      (##[0:300] frame_end))
    else $error("voice id not with second beacon frame"); // R06

  a_no_flight_debug: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i)
    frame_start_o && $past(flight_cfg_i) |-> frame_type_o != 4'h0)
    else $error("debug frame in flight configuration"); // R07

  a_pad_zero: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    buf_in_fire && byte_idx_r > `STFS_LAST_DATA_BYTE |-> buf_in_data == 8'h00)
    else $error("pad byte not zero"); // R19

  a_frame_len: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    state_r == STFS_S_STREAM ##1 state_r == STFS_S_WAIT |->
      byte_idx_r == 6'h3A)
    else $error("real-time frame not 58 bytes"); // R08

  a_diag_place: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i)
    state_r == STFS_S_START |=>
      payload_r[`STFS_OFF_DIAG +: `STFS_DIAG_W] == $past(diag_i) &&
      payload_r[`STFS_OFF_SPIN +: `STFS_FLD_W] == $past(spin_i))
    else $error("diagnostic or spin field misplaced"); // R15

  a_byte_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    byte_valid_o && !byte_ready_i |=> byte_valid_o && $stable(byte_o))
    else $error("stalled byte lost"); // R17

endmodule : stfs_frame_scheduler

// *** rtl/stfs_pair_buffer.sv ***
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`include "stfs_regs.svh"

module stfs_pair_buffer #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic ref_clk_i, // system clock
  input wire logic nrst_i, // async reset, active low
  input wire logic in_valid_i, // word offered
  input wire logic [WIDTH-1:0] in_data_i, // word in
  output logic in_ready_o, // room for a word
  output logic out_valid_o, // word available
  output logic [WIDTH-1:0] out_data_o, // oldest word
  input wire logic out_ready_i // drain side takes word
);
  import stfs_pkg::*;

  logic [WIDTH-1:0] tail_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic in_fire;
  logic out_fire;

  assign in_fire = in_valid_i & in_ready_o;
  assign out_fire = out_valid_o & out_ready_i;

  always_comb begin
    cnt_nxt = cnt_r + {1'b0, in_fire} - {1'b0, out_fire};
  end

  // ****************************************
  // occupancy and handshake flags
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= 2'h0;
      out_valid_o <= 1'b0;
      in_ready_o <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_valid_o <= (cnt_nxt != 2'h0);
      in_ready_o <= (cnt_nxt != `STFS_BUF_FULL);
    end
  end

  // ****************************************
  // storage: head always drives the output
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_data_o <= '0;
      tail_r <= '0;
    end else if (out_fire) begin
      if (cnt_r == `STFS_BUF_FULL) begin
        out_data_o <= tail_r;
        if (in_fire) begin
          tail_r <= in_data_i;
        end
      end else if (in_fire) begin
        out_data_o <= in_data_i;
      end
    end else if (in_fire) begin
      if (cnt_r == 2'h0) begin
        out_data_o <= in_data_i;
      end else begin
        tail_r <= in_data_i;
      end
    end
  end

endmodule : stfs_pair_buffer

// *** rtl/stfs_pkg.sv ***
// types shared by the slow telemetry frame scheduler
package stfs_pkg;

  typedef enum logic [1:0] {
    STFS_S_IDLE,
    STFS_S_START,
    STFS_S_STREAM,
    STFS_S_WAIT
  } stfs_state_t;

  typedef enum logic {
    STFS_M_ROT,
    STFS_M_BCN
  } stfs_mode_t;

endpackage : stfs_pkg

// *** rtl/stfs_regs.svh ***
// offsets, field positions, reset values and counts of the frame scheduler
`ifndef STFS_REGS_SVH
`define STFS_REGS_SVH

// payload type codes
`define STFS_PTYPE_DEBUG 4'h0
`define STFS_PTYPE_RT 4'h1
`define STFS_PTYPE_MAXV 4'h2
`define STFS_PTYPE_MINV 4'h3
`define STFS_PTYPE_RAD 4'h4

// rotation table shape
`define STFS_ROT_LAST 5'h17
`define STFS_ROT_MAXV_IDX 5'h0A
`define STFS_ROT_MINV_IDX 5'h16
`define STFS_ROT_STRIDE 5'h03

// real-time payload framing
`define STFS_RT_BITS 429
`define STFS_PAD_BITS 464
`define STFS_LAST_BYTE 6'h39
`define STFS_LAST_DATA_BYTE 6'h35

// field widths
`define STFS_FLD_W 12
`define STFS_W3 36
`define STFS_W5 60
`define STFS_W6 72
`define STFS_DIAG_W 32
`define STFS_FAIL_W 4
`define STFS_TAIL_W 9

// field bit offsets inside the real-time payload
`define STFS_OFF_PACK_V 0
`define STFS_OFF_PACK_T 36
`define STFS_OFF_PACK_I 72
`define STFS_OFF_BRD_T 84
`define STFS_OFF_PANEL_V 96
`define STFS_OFF_PANEL_T 168
`define STFS_OFF_SUPPLY_T 240
`define STFS_OFF_SPIN 252
`define STFS_OFF_RADIO 264
`define STFS_OFF_ANG 324
`define STFS_OFF_EXP_FOUR_T 360
`define STFS_OFF_SUPPLY_I 372
`define STFS_OFF_DIAG 384
`define STFS_OFF_EXP_FAIL 416
`define STFS_OFF_TAIL 420

// buffer occupancy and reset values
`define STFS_BUF_FULL 2'h2
`define STFS_RST_TYPE 4'h0
`define STFS_RST_BYTE 8'h00

`endif

// *** tb/slow_telemetry_frame_scheduler_test.sv ***
// self-checking bench of the slow telemetry frame scheduler
`timescale 1ns/1ps
`include "stfs_regs.svh"

module slow_telemetry_frame_scheduler_test;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic keying_req_i = 1'b0, beacon_req_i = 1'b0, flight_cfg_i = 1'b0;
  logic debug_sel_i = 1'b0, stall_en = 1'b0;
  logic [35:0] bv = 36'h123456789, bt = 36'hABCDEF012;
  logic [11:0] bi = 12'h8F1, brd = 12'h2C3, pst = 12'h4D5, spin = 12'hA6B;
  logic [11:0] e4t = 12'h7E8, psi = 12'h19A;
  logic [71:0] pv = 72'h0123456789ABCDEF01, pt = 72'hFEDCBA987654321012;
  logic [59:0] rad = 60'h13579BDF2468ACE;
  logic [35:0] ang = 36'h9876543A1;
  logic [31:0] diag = 32'hDEADC0DE;
  logic [3:0] fail = 4'h9;
  logic [8:0] tail = 9'h1A5;
  logic byte_ready, frame_done, transmit_keying_o, frame_start_o;
  logic voice_id_o, byte_valid_o;
  logic [3:0] frame_type_o;
  logic [7:0] byte_o;
  logic [463:0] pl;
  int err_total = 0, checks = 0;
  localparam logic [3:0] ROT [24] = '{4'h1, 4'h4, 4'h4, 4'h1, 4'h4, 4'h4,
    4'h1, 4'h4, 4'h4, 4'h1, 4'h2, 4'h4, 4'h1, 4'h4, 4'h4, 4'h1, 4'h4, 4'h4,
    4'h1, 4'h4, 4'h4, 4'h1, 4'h3, 4'h4};

  always #20 ref_clk_i = ~ref_clk_i;

  stfs_frame_scheduler stfs_frame_scheduler_inst (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .keying_req_i(keying_req_i), .beacon_req_i(beacon_req_i),
    .flight_cfg_i(flight_cfg_i), .debug_sel_i(debug_sel_i),
    .frame_done_i(frame_done), .pack_volt_i(bv), .pack_temp_i(bt),
    .pack_curr_i(bi), .pack_brd_temp_i(brd), .panel_volt_i(pv),
    .panel_temp_i(pt), .supply_temp_i(pst), .spin_i(spin), .radio_i(rad),
    .ang_vel_i(ang), .exp_four_temp_i(e4t), .supply_curr_i(psi),
    .diag_i(diag),
    .exp_fail_i(fail), .tail_i(tail), .byte_ready_i(byte_ready),
    .transmit_keying_o(transmit_keying_o), .frame_start_o(frame_start_o),
    .frame_type_o(frame_type_o), .voice_id_o(voice_id_o), .byte_o(byte_o),
    .byte_valid_o(byte_valid_o));

  stfs_tx_model stfs_tx_model_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .frame_start_i(frame_start_o), .frame_type_i(frame_type_o),
    .byte_i(byte_o), .byte_valid_i(byte_valid_o), .stall_en_i(stall_en),
    .byte_ready_o(byte_ready), .frame_done_o(frame_done));

  // ******************************************************************
  // shared tasks
  // ******************************************************************
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // waits at falling edges, where outputs have settled
  task automatic wait_for(input int which, output logic [3:0] t);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < 3000) begin
      @(negedge ref_clk_i);
      n++;
      case (which)
        0: hit = (frame_start_o === 1'b1);
        1: hit = (frame_done === 1'b1);
        default: hit = (transmit_keying_o === 1'b0);
      endcase
    end
    if (!hit) begin
      err_total++;
      wrap_up();
    end
    t = frame_type_o;
  endtask : wait_for

  task automatic set_key(input logic v);
    @(posedge ref_clk_i);
    keying_req_i <= v;
  endtask : set_key

  // ******************************************************************
  // scenarios
  // ******************************************************************
  task automatic rotation_test();
    logic [3:0] t;
    set_key(1'b1);
    for (int i = 0; i < 26; i++) begin
      wait_for(0, t);
      chk(t, ROT[i % 24]);
    end
    set_key(1'b0);
    @(negedge ref_clk_i);
    chk(transmit_keying_o, 1'b1);
    wait_for(1, t);
    chk(transmit_keying_o, 1'b1);
    repeat (3) @(negedge ref_clk_i);
    chk(transmit_keying_o, 1'b0);
  endtask : rotation_test

  task automatic payload_test();
    logic [3:0] t;
    logic [7:0] cb;
    pl = '0;
    pl[428:0] = {tail, fail, diag, psi, e4t, ang, rad, spin, pst, pt, pv,
      brd, bi, bt, bv};
    stall_en = 1'b1;
    set_key(1'b1);
    wait_for(0, t);
    chk(t, 4'h1);
    set_key(1'b0);
    wait_for(1, t);
    for (int k = 0; k < 58; k++) begin
      cb = stfs_tx_model_inst.cap_r[k];
      chk(cb, pl[8*k+:8]);
    end
    wait_for(2, t);
    stall_en = 1'b0;
  endtask : payload_test

  task automatic beacon_test();
    logic [3:0] t;
    for (int b = 0; b < 3; b++) begin
      @(posedge ref_clk_i);
      beacon_req_i <= 1'b1;
      @(posedge ref_clk_i);
      beacon_req_i <= 1'b0;
      wait_for(0, t);
      chk(t, 4'h1);
      chk(voice_id_o, 1'b0);
      wait_for(0, t);
      chk(t, (b == 1) ? 4'h3 : 4'h2);
      chk(voice_id_o, 1'b1);
      wait_for(1, t);
      chk(voice_id_o, 1'b1);
      wait_for(2, t);
    end
  endtask : beacon_test

  task automatic debug_test();
    logic [3:0] t;
    for (int f = 1; f >= 0; f--) begin
      @(posedge ref_clk_i);
      debug_sel_i <= 1'b1;
      flight_cfg_i <= f[0];
      set_key(1'b1);
      wait_for(0, t);
      chk(t, f[0] ? 4'h1 : 4'h0);
      set_key(1'b0);
      wait_for(2, t);
    end
    @(posedge ref_clk_i);
    debug_sel_i <= 1'b0;
  endtask : debug_test

  initial begin
    repeat (8) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rotation_test();
    payload_test();
    beacon_test();
    debug_test();
    wrap_up();
  end
endmodule : slow_telemetry_frame_scheduler_test

// *** tb/stfs_tx_model.sv ***
// transmitter model: takes payload bytes and reports each frame as sent
`timescale 1ns/1ps

module stfs_tx_model (
  input wire logic ref_clk_i, // system clock
  input wire logic nrst_i, // async reset, active low
  input wire logic frame_start_i, // new frame begins
  input wire logic [3:0] frame_type_i, // payload type
  input wire logic [7:0] byte_i, // payload byte
  input wire logic byte_valid_i, // byte offered
  input wire logic stall_en_i, // stall half of the time
  output logic byte_ready_o, // byte taken this cycle
  output logic frame_done_o // frame fully sent
);
  logic [7:0] cap_r [0:57];
  logic [5:0] cnt_r;
  logic [2:0] ph_r;
  logic [2:0] dly_r;
  logic busy_r;
  logic streamed;

  assign streamed = (frame_type_i inside {4'h1, 4'h2, 4'h3});

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph_r <= 3'h0;
      byte_ready_o <= 1'b0;
      frame_done_o <= 1'b0;
      cnt_r <= 6'h00;
      dly_r <= 3'h0;
      busy_r <= 1'b0;
    end else begin
      ph_r <= ph_r + 3'h1;
      // four cycles of stall in every eight fill the buffer
      byte_ready_o <= !(stall_en_i && ph_r[2]);
      frame_done_o <= 1'b0;
      if (frame_start_i) begin
        cnt_r <= 6'h00;
        dly_r <= 3'h0;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        dly_r <= dly_r + 3'h1;
        if (byte_valid_i && byte_ready_o) begin
          cap_r[cnt_r] <= byte_i;
          cnt_r <= cnt_r + 6'h01;
        end
        // done only once the whole frame has gone out
        if (streamed ? (cnt_r == 6'h3A) : (dly_r == 3'h4)) begin
          frame_done_o <= 1'b1;
          busy_r <= 1'b0;
        end
      end
    end
  end
endmodule : stfs_tx_model
